// [abwit_apd_timer.sv]
`timescale 1ns/10ps
// automatic power-down countdown: one-second prescaler plus seconds counter
module abwit_apd_timer #(
   parameter int unsigned TICK_CYCLES = abwit_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic arm, // load period and start counting
   input wire logic halt, // stop and clear the prescaler; seconds left are kept
   input wire logic [7:0] period_code, // sector_count value of the idle command
   output logic running,
   output logic expired // one-cycle pulse at zero
);
   localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   generate
      if (TICK_CYCLES < 2) begin : g_bad_tick
         $error("tick period must be at least two cycles");
      end
   endgenerate

   // period decode into whole seconds
   function automatic logic [abwit_pkg::SEC_W-1:0] period_secs(input logic [7:0] code);
      int s;
      s = abwit_pkg::T21M15_S; // codes 254 and 255
      if (code <= 8'(abwit_pkg::LONG_BASE)) begin
         s = int'(code) * abwit_pkg::SHORT_UNIT_S;
      end else if (code <= 8'(abwit_pkg::LONG_LAST)) begin
         s = (int'(code) - abwit_pkg::LONG_BASE) * abwit_pkg::LONG_UNIT_S;
      end else if (code == abwit_pkg::CODE_21M) begin
         s = abwit_pkg::T21M_S;
      end else if (code == abwit_pkg::CODE_8H) begin
         s = abwit_pkg::T8H_S;
      end
      return s[abwit_pkg::SEC_W-1:0];
   endfunction

   logic run_r, run_nxt; // countdown active
   logic [PW-1:0] pre_r, pre_nxt; // cycles within the current second
   logic [abwit_pkg::SEC_W-1:0] sec_r, sec_nxt; // seconds left
   logic exp_r, exp_nxt;

   // next-state: arm beats halt so a completing command can restart at once
   always_comb begin
      run_nxt = run_r;
      pre_nxt = pre_r;
      sec_nxt = sec_r;
      exp_nxt = 1'b0;
      if (arm) begin
         run_nxt = (period_code != 8'h00);
         pre_nxt = '0;
         sec_nxt = period_secs(period_code);
      end else if (halt) begin
         run_nxt = 1'b0;
         pre_nxt = '0;
      end else if (run_r) begin
         if (pre_r == PRE_LAST) begin
            pre_nxt = '0; // one-second tick
            sec_nxt = sec_r - 1'b1;
            if (sec_r == 1) begin
               run_nxt = 1'b0;
               exp_nxt = 1'b1;
            end
         end else begin
            pre_nxt = pre_r + 1'b1;
         end
      end
   end

   // registers only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run_r <= 1'b0;
         pre_r <= '0;
         sec_r <= '0;
         exp_r <= 1'b0;
      end else begin
         run_r <= run_nxt;
         pre_r <= pre_nxt;
         sec_r <= sec_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign running = run_r;
   assign expired = exp_r;
endmodule

// [abwit_host.sv]
`timescale 1ns/10ps
// host adapter model: one task-file access per clock, strobes held to the taking edge
module abwit_host (
   input wire logic sys_clk,
   output logic [9:0] tf_addr,
   output logic tf_wr,
   output logic tf_rd,
   output logic [15:0] tf_wdata,
   input wire logic [15:0] tf_rdata
);
   // quiet bus at time zero
   initial begin
      tf_addr = 10'h000;
      tf_wr = 1'b0;
      tf_rd = 1'b0;
      tf_wdata = 16'h0000;
   end
   // one access, taken at the next rising edge; read data is settled on return
   task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      tf_wr = w;
      tf_rd = ~w;
      tf_addr = a;
      // reads flip the data lines so a stale word never looks meaningful
      tf_wdata = w ? d : ~tf_wdata;
      @(posedge sys_clk);
      #1;
      q = tf_rdata;
   endtask
   // release; waits one edge so no strobe is raised again in the same step
   task automatic rel();
      tf_wr = 1'b0;
      tf_rd = 1'b0;
      tf_wdata = ~tf_wdata;
      tf_addr = ~tf_addr;
      @(posedge sys_clk);
      #1;
   endtask
   // opcode write for buffer load, idle or an unknown opcode
   task automatic cmd(input logic [7:0] op);
      logic [15:0] q;
      acc(1'b1, abwit_pkg::REG_CMD, {8'h00, op}, q);
   endtask
endmodule

// [abwit_pkg.sv]
package abwit_pkg;
   // task-file register offsets, ten-bit host address
   localparam logic [9:0] REG_DATA = 10'h1F0; // 16-bit data port
   localparam logic [9:0] REG_FAULT = 10'h1F1; // fault_code on read, features_port on write
   localparam logic [9:0] REG_SCNT = 10'h1F2; // sector_count
   localparam logic [9:0] REG_SNUM = 10'h1F3; // sector_number
   localparam logic [9:0] REG_CYLL = 10'h1F4; // cylinder_low
   localparam logic [9:0] REG_CYLH = 10'h1F5; // cylinder_high
   localparam logic [9:0] REG_DHS = 10'h1F6; // drive_head_select
   localparam logic [9:0] REG_CMD = 10'h1F7; // condition_flags on read, opcode_port on write

   // opcodes
   localparam logic [7:0] OP_BUF_LOAD = 8'hE8;
   localparam logic [7:0] OP_IDLE_A = 8'h97;
   localparam logic [7:0] OP_IDLE_B = 8'hE3;

   // condition_flags bit positions
   localparam int FLG_BUSY = 7;
   localparam int FLG_READY = 6;
   localparam int FLG_SEEKDONE = 4;
   localparam int FLG_DREQ = 3;
   localparam int FLG_FAULT = 0;
   // fault_code bit for an aborted command
   localparam int FLT_ABORT = 2;

   // values after reset
   localparam logic [7:0] RST_TASKREG = 8'h00;
   localparam logic [7:0] RST_SCNT = 8'h01;
   localparam logic [15:0] RST_RDATA = 16'h0000;

   // sector transfer: 512 bytes as 256 words of 16 bits
   localparam int SECTOR_BYTES = 512;
   localparam int WORD_BYTES = 2;
   localparam int SECTOR_WORDS = SECTOR_BYTES / WORD_BYTES;

   // clock and power-down timing
   localparam int CLK_HZ = 10_000_000; // sys_clk rate, 100 ns period
   localparam int TICK_PERIOD_S = 1; // prescaler tick, seconds
   localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;
   localparam int SHORT_UNIT_S = 5; // counts 1..240
   localparam int LONG_UNIT_MIN = 30; // counts 241..251
   localparam int LONG_UNIT_S = LONG_UNIT_MIN * 60;
   localparam int LONG_BASE = 240;
   localparam int LONG_LAST = 251;
   localparam logic [7:0] CODE_21M = 8'hFC;
   localparam logic [7:0] CODE_8H = 8'hFD;
   localparam int T21M_S = 21 * 60;
   localparam int T8H_S = 8 * 3600;
   localparam int T21M15_S = 21 * 60 + 15;
   localparam int SEC_W = 15; // holds eight hours of seconds

   // command sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_READY = 5'b00001, // waiting for an opcode
      ST_WB_PREP = 5'b00010, // busy, setting up the buffer
      ST_WB_XFER = 5'b00100, // data-request, taking words
      ST_IDLE_EXEC = 5'b01000, // busy, entering idle
      ST_ABORT = 5'b10000 // busy, rejecting an unknown opcode
   } abwit_state_t;
endpackage

// [abwit_top.sv]
`timescale 1ns/10ps
// task-file command interpreter for buffer load and idle with power-down timer
module abwit_top #(
   parameter int unsigned TICK_CYCLES = abwit_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [9:0] tf_addr, // task-file address
   input wire logic tf_wr, // one-cycle write strobe
   input wire logic tf_rd, // one-cycle read strobe
   input wire logic [15:0] tf_wdata, // low byte used for 8-bit registers
   output logic [15:0] tf_rdata, // registered, valid the cycle after tf_rd
   output logic intrq, // host interrupt line
   input wire logic spindle_rotating, // spindle already at speed
   output logic spin_up_req, // one-cycle pulse
   output logic spin_down_req, // one-cycle pulse on timer standby
   output logic idle_mode,
   output logic standby_mode,
   output logic apd_enabled, // automatic power-down armed
   input wire logic [7:0] buf_rd_addr, // drive-side buffer word address
   output logic [15:0] buf_rd_data // registered word from the buffer
);
   localparam int WCW = $clog2(abwit_pkg::SECTOR_WORDS);
   localparam logic [WCW-1:0] WC_LAST = WCW'(abwit_pkg::SECTOR_WORDS - 1);

   generate
      if (abwit_pkg::SECTOR_WORDS != 256) begin : g_bad_words
         $error("buffer address port assumes 256 words");
      end
   endgenerate

   // sector buffer, written only by the host during data-request
   logic [15:0] sbuf [abwit_pkg::SECTOR_WORDS];

   abwit_pkg::abwit_state_t state_r, state_nxt;
   logic [WCW-1:0] wcnt_r, wcnt_nxt; // words taken so far
   logic bsy_r, bsy_nxt;
   logic drq_r, drq_nxt;
   logic err_r, err_nxt;
   logic intrq_r, intrq_nxt;
   logic [7:0] fault_r, fault_nxt;
   logic [7:0] scnt_r, scnt_nxt;
   logic [7:0] snum_r, snum_nxt;
   logic [7:0] cyll_r, cyll_nxt;
   logic [7:0] cylh_r, cylh_nxt;
   logic [7:0] dhs_r, dhs_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic idle_r, idle_nxt;
   logic stby_r, stby_nxt;
   logic apd_r, apd_nxt;
   logic spup_r, spup_nxt;
   logic spdn_r, spdn_nxt;
   logic [15:0] bufq_r;
   logic tmr_arm, tmr_halt; // timer controls, combinational
   logic tmr_run, tmr_exp;
   logic [7:0] flags; // condition_flags as read
   logic cmd_wr, dat_wr, is_idle_op;

   // opcode writes count only while the device is ready; busy ignores them
   assign cmd_wr = tf_wr && tf_addr == abwit_pkg::REG_CMD && state_r == abwit_pkg::ST_READY;
   assign dat_wr = tf_wr && tf_addr == abwit_pkg::REG_DATA && state_r == abwit_pkg::ST_WB_XFER;
   assign is_idle_op = tf_wdata[7:0] == abwit_pkg::OP_IDLE_A
                    || tf_wdata[7:0] == abwit_pkg::OP_IDLE_B;

   always_comb begin
      flags = 8'h00;
      flags[abwit_pkg::FLG_BUSY] = bsy_r;
      flags[abwit_pkg::FLG_READY] = 1'b1;
      flags[abwit_pkg::FLG_SEEKDONE] = 1'b1;
      flags[abwit_pkg::FLG_DREQ] = drq_r;
      flags[abwit_pkg::FLG_FAULT] = err_r;
   end

   abwit_apd_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .arm(tmr_arm),
      .halt(tmr_halt),
      .period_code(scnt_r),
      .running(tmr_run),
      .expired(tmr_exp)
   );

   // sequencer, task-file registers and power state
   always_comb begin
      state_nxt = state_r;
      wcnt_nxt = wcnt_r;
      bsy_nxt = bsy_r;
      drq_nxt = drq_r;
      err_nxt = err_r;
      intrq_nxt = intrq_r;
      fault_nxt = fault_r;
      scnt_nxt = scnt_r;
      snum_nxt = snum_r;
      cyll_nxt = cyll_r;
      cylh_nxt = cylh_r;
      dhs_nxt = dhs_r;
      rdata_nxt = rdata_r;
      idle_nxt = idle_r;
      stby_nxt = stby_r;
      apd_nxt = apd_r;
      spup_nxt = 1'b0;
      spdn_nxt = 1'b0;
      tmr_arm = 1'b0;
      tmr_halt = 1'b0;

      // host reads: status read acknowledges the interrupt
      if (tf_rd) begin
         case (tf_addr)
            abwit_pkg::REG_CMD: begin
               rdata_nxt = {8'h00, flags};
               intrq_nxt = 1'b0;
            end
            abwit_pkg::REG_FAULT: rdata_nxt = {8'h00, fault_r};
            abwit_pkg::REG_SCNT: rdata_nxt = {8'h00, scnt_r};
            abwit_pkg::REG_SNUM: rdata_nxt = {8'h00, snum_r};
            abwit_pkg::REG_CYLL: rdata_nxt = {8'h00, cyll_r};
            abwit_pkg::REG_CYLH: rdata_nxt = {8'h00, cylh_r};
            abwit_pkg::REG_DHS: rdata_nxt = {8'h00, dhs_r};
            default: rdata_nxt = 16'h0000; // data port and unmapped read zero
         endcase
      end

      // parameter writes are dropped while busy
      if (tf_wr && !bsy_r) begin
         case (tf_addr)
            abwit_pkg::REG_SCNT: scnt_nxt = tf_wdata[7:0];
            abwit_pkg::REG_SNUM: snum_nxt = tf_wdata[7:0];
            abwit_pkg::REG_CYLL: cyll_nxt = tf_wdata[7:0];
            abwit_pkg::REG_CYLH: cylh_nxt = tf_wdata[7:0];
            abwit_pkg::REG_DHS: dhs_nxt = tf_wdata[7:0];
            default: ;
         endcase
      end

      // timer expiry while idle drops to standby
      if (tmr_exp && idle_r) begin
         idle_nxt = 1'b0;
         stby_nxt = 1'b1;
         spdn_nxt = 1'b1;
      end

      case (state_r)
         abwit_pkg::ST_READY: begin
            if (cmd_wr) begin
               tmr_halt = 1'b1;
               bsy_nxt = 1'b1;
               err_nxt = 1'b0;
               fault_nxt = 8'h00;
               intrq_nxt = 1'b0; // a new command withdraws the old interrupt
               if (tf_wdata[7:0] == abwit_pkg::OP_BUF_LOAD) begin
                  state_nxt = abwit_pkg::ST_WB_PREP;
               end else if (is_idle_op) begin
                  state_nxt = abwit_pkg::ST_IDLE_EXEC;
               end else begin
                  state_nxt = abwit_pkg::ST_ABORT;
               end
            end
         end
         abwit_pkg::ST_WB_PREP: begin
            // buffer is always writable, so one busy cycle suffices
            wcnt_nxt = '0;
            bsy_nxt = 1'b0;
            drq_nxt = 1'b1;
            state_nxt = abwit_pkg::ST_WB_XFER;
         end
         abwit_pkg::ST_WB_XFER: begin
            if (dat_wr) begin
               wcnt_nxt = wcnt_r + 1'b1;
               if (wcnt_r == WC_LAST) begin
                  drq_nxt = 1'b0;
                  intrq_nxt = 1'b1;
                  state_nxt = abwit_pkg::ST_READY;
                  tmr_arm = apd_r && idle_r;
               end
            end
         end
         abwit_pkg::ST_IDLE_EXEC: begin
            // interrupt goes out now; spindle settles on its own
            bsy_nxt = 1'b0;
            intrq_nxt = 1'b1;
            idle_nxt = 1'b1;
            stby_nxt = 1'b0;
            spup_nxt = !spindle_rotating;
            apd_nxt = scnt_r != 8'h00;
            tmr_arm = scnt_r != 8'h00;
            state_nxt = abwit_pkg::ST_READY;
         end
         abwit_pkg::ST_ABORT: begin
            // unknown opcode: fail it and restart the countdown
            bsy_nxt = 1'b0;
            err_nxt = 1'b1;
            fault_nxt[abwit_pkg::FLT_ABORT] = 1'b1;
            intrq_nxt = 1'b1;
            tmr_arm = apd_r && idle_r;
            state_nxt = abwit_pkg::ST_READY;
         end
         default: begin
            state_nxt = abwit_pkg::ST_READY;
            bsy_nxt = 1'b0;
            drq_nxt = 1'b0;
         end
      endcase
   end

   // registers only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= abwit_pkg::ST_READY;
         wcnt_r <= '0;
         bsy_r <= 1'b0;
         drq_r <= 1'b0;
         err_r <= 1'b0;
         intrq_r <= 1'b0;
         fault_r <= abwit_pkg::RST_TASKREG;
         scnt_r <= abwit_pkg::RST_SCNT;
         snum_r <= abwit_pkg::RST_TASKREG;
         cyll_r <= abwit_pkg::RST_TASKREG;
         cylh_r <= abwit_pkg::RST_TASKREG;
         dhs_r <= abwit_pkg::RST_TASKREG;
         rdata_r <= abwit_pkg::RST_RDATA;
         idle_r <= 1'b1;
         stby_r <= 1'b0;
         apd_r <= 1'b0;
         spup_r <= 1'b0;
         spdn_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wcnt_r <= wcnt_nxt;
         bsy_r <= bsy_nxt;
         drq_r <= drq_nxt;
         err_r <= err_nxt;
         intrq_r <= intrq_nxt;
         fault_r <= fault_nxt;
         scnt_r <= scnt_nxt;
         snum_r <= snum_nxt;
         cyll_r <= cyll_nxt;
         cylh_r <= cylh_nxt;
         dhs_r <= dhs_nxt;
         rdata_r <= rdata_nxt;
         idle_r <= idle_nxt;
         stby_r <= stby_nxt;
         apd_r <= apd_nxt;
         spup_r <= spup_nxt;
         spdn_r <= spdn_nxt;
      end
   end

   // buffer array, no reset so it maps onto block memory
   always_ff @(posedge sys_clk) begin
      if (dat_wr) begin
         sbuf[wcnt_r] <= tf_wdata;
      end
      bufq_r <= sbuf[buf_rd_addr];
   end

   assign tf_rdata = rdata_r;
   assign intrq = intrq_r;
   assign spin_up_req = spup_r;
   assign spin_down_req = spdn_r;
   assign idle_mode = idle_r;
   assign standby_mode = stby_r;
   assign apd_enabled = apd_r;
   assign buf_rd_data = bufq_r;

   // checks
   wb_decode_a: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_wr && tf_wdata[7:0] == abwit_pkg::OP_BUF_LOAD |=> bsy_r && !drq_r ##1 drq_r && !bsy_r)
      else $error("buffer load opcode not started");
   wb_dreq_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(drq_r) |-> $past(bsy_r) && !bsy_r)
      else $error("data-request without preceding busy");
   wb_words_a: assert property (@(posedge sys_clk) disable iff (rst)
      dat_wr && wcnt_r != WC_LAST |=> drq_r && !intrq_r)
      else $error("buffer load ended early");
   wb_last_a: assert property (@(posedge sys_clk) disable iff (rst)
      dat_wr && wcnt_r == WC_LAST |=> intrq_r && !drq_r && state_r == abwit_pkg::ST_READY)
      else $error("no interrupt after last word");
   idle_decode_a: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_wr && is_idle_op |=> state_r == abwit_pkg::ST_IDLE_EXEC && bsy_r)
      else $error("idle opcode not decoded");
   idle_done_a: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_wr && is_idle_op |=> ##1 !bsy_r && intrq_r && idle_r && !stby_r)
      else $error("idle command did not complete");
   idle_nowait_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_IDLE_EXEC && !spindle_rotating |=> intrq_r && spup_r)
      else $error("idle interrupt waited for spindle");
   no_spinup_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_IDLE_EXEC && spindle_rotating |=> !spup_r)
      else $error("spin-up requested while rotating");
   apd_start_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_IDLE_EXEC && scnt_r != 8'h00 |=> apd_r && tmr_run)
      else $error("power-down timer not started");
   to_standby_a: assert property (@(posedge sys_clk) disable iff (rst)
      tmr_exp && idle_r |=> stby_r && !idle_r && spdn_r)
      else $error("expiry did not enter standby");
   apd_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_IDLE_EXEC && scnt_r == 8'h00 |=> !apd_r && !tmr_run)
      else $error("zero period left timer on");
   cmd_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_wr |=> !tmr_run)
      else $error("command did not stop the timer");
   restart_a: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_ABORT && apd_r && idle_r && scnt_r != 8'h00 |=> tmr_run)
      else $error("timer not restarted after command");

   wb_done_c: cover property (@(posedge sys_clk) disable iff (rst)
      dat_wr && wcnt_r == WC_LAST);
   idle_apd_c: cover property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_IDLE_EXEC && scnt_r != 8'h00);
   expire_c: cover property (@(posedge sys_clk) disable iff (rst) tmr_exp && idle_r);
   abort_c: cover property (@(posedge sys_clk) disable iff (rst)
      state_r == abwit_pkg::ST_ABORT);
endmodule

// [abwit_top_bench.sv]
`timescale 1ns/10ps
// bench: register access, sector load, idle and power-down timing
module abwit_top_bench;
   localparam int TK = 2; // shortened second keeps the eight-hour code affordable
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] tf_addr;
   logic tf_wr;
   logic tf_rd;
   logic [15:0] tf_wdata;
   logic [15:0] tf_rdata;
   logic intrq;
   logic spindle_rotating = 1'b1; // spindle state seen by the device
   logic spin_up_req;
   logic spin_down_req;
   logic idle_mode;
   logic standby_mode;
   logic apd_enabled;
   logic [7:0] buf_rd_addr = 8'h00; // drive-side buffer probe
   logic [15:0] buf_rd_data;
   int n_fail = 0;
   int check_count = 0;
   int n_up = 0; // spin-up pulses seen
   int n_down = 0; // spin-down pulses seen
   logic [31:0] seed = 32'h0000004E;
   logic [31:0] r;
   logic [15:0] q;
   logic [15:0] wbuf [256]; // words sent in the last sector load
   logic [7:0] codes [8];

   abwit_top #(.TICK_CYCLES(TK)) uut (.sys_clk(sys_clk), .rst(rst), .tf_addr(tf_addr),
      .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata),
      .intrq(intrq), .spindle_rotating(spindle_rotating), .spin_up_req(spin_up_req),
      .spin_down_req(spin_down_req), .idle_mode(idle_mode), .standby_mode(standby_mode),
      .apd_enabled(apd_enabled), .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data));
   abwit_host host (.sys_clk(sys_clk), .tf_addr(tf_addr), .tf_wr(tf_wr), .tf_rd(tf_rd),
      .tf_wdata(tf_wdata), .tf_rdata(tf_rdata));

   // 100 ns clock
   always #50 sys_clk = ~sys_clk;
   // count one-cycle spindle pulses
   always @(posedge sys_clk) begin
      if (spin_up_req === 1'b1) n_up++;
      if (spin_down_req === 1'b1) n_down++;
   end

   // xorshift stream
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // seconds for a period code
   function automatic int secs(input logic [7:0] c);
      if (c <= 8'hF0) return c * 5;
      if (c <= 8'hFB) return (c - 240) * 1800;
      if (c == 8'hFC) return 1260;
      if (c == 8'hFD) return 28800;
      return 1275;
   endfunction
   // register values after reset; status shows ready and seek done only
   function automatic logic [15:0] rst_val(input logic [9:0] a);
      if (a == abwit_pkg::REG_SCNT) return 16'h0001;
      if (a == abwit_pkg::REG_CMD) return 16'h0050;
      return 16'h0000;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [9:0] a);
      host.acc(1'b0, a, 16'h0000, q);
      host.rel();
   endtask
   // idle command with busy read in c1 and done state in c2
   task automatic do_idle(input logic [7:0] op, input logic [7:0] c, input logic sp);
      int u;
      spindle_rotating = sp;
      host.acc(1'b1, abwit_pkg::REG_SCNT, {8'h00, c}, q);
      u = n_up;
      host.cmd(op);
      host.acc(1'b0, abwit_pkg::REG_CMD, 16'h0000, q);
      check(q, 16'h00D0);
      check(intrq, 1'b1);
      check(idle_mode & ~standby_mode, 1'b1);
      check(apd_enabled, c != 8'h00);
      host.acc(1'b0, abwit_pkg::REG_CMD, 16'h0000, q);
      host.rel();
      check(q, 16'h0050);
      check(n_up - u, sp ? 0 : 1);
   endtask
   // wait for timer standby, e cycles expected from now
   task automatic wait_sb(input int e);
      int n;
      int d;
      n = 0;
      d = n_down;
      while (standby_mode !== 1'b1 && n < e + 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check(n >= e - TK - 3 && n <= e + TK + 3, 1'b1);
      if (n >= e + 20) finish_test();
      @(posedge sys_clk);
      #1;
      check(idle_mode, 1'b0);
      check(n_down - d, 1);
   endtask
   // buffer load: busy, data-request, 255 words, then the last one
   task automatic load();
      host.cmd(abwit_pkg::OP_BUF_LOAD);
      host.acc(1'b0, abwit_pkg::REG_CMD, 16'h0000, q);
      check(q, 16'h00D0);
      host.acc(1'b0, abwit_pkg::REG_CMD, 16'h0000, q);
      check(q, 16'h0058);
      for (int k = 0; k < 256; k++) begin
         r = xs();
         wbuf[k] = r[15:0];
         if (k == 255) check(intrq, 1'b0);
         host.acc(1'b1, abwit_pkg::REG_DATA, wbuf[k], q);
      end
      check(intrq, 1'b1);
      host.rel();
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      for (int a = 10'h1F0; a <= 10'h1F8; a++) begin
         rd(a[9:0]);
         check(q, rst_val(a[9:0]));
      end
      for (int a = 10'h1F2; a <= 10'h1F6; a++) begin
         r = xs();
         host.acc(1'b1, a[9:0], {8'hA5, r[7:0]}, q);
         rd(a[9:0]);
         check(q, {8'h00, r[7:0]});
      end
      $display("test regs done");
      load();
      rd(abwit_pkg::REG_CMD);
      check(q, 16'h0050);
      for (int k = 0; k < 256; k++) begin
         buf_rd_addr = k[7:0];
         @(posedge sys_clk);
         #1;
         check(buf_rd_data, wbuf[k]);
      end
      $display("test load done");
      // a command mid-countdown halts the timer, completion restarts it
      do_idle(abwit_pkg::OP_IDLE_A, 8'h04, 1'b1);
      repeat (10) @(posedge sys_clk);
      #1;
      load();
      check(standby_mode, 1'b0);
      wait_sb(secs(8'h04) * TK - 1);
      $display("test restart done");
      do_idle(abwit_pkg::OP_IDLE_B, 8'h00, 1'b0);
      repeat (100) @(posedge sys_clk);
      #1;
      check(standby_mode, 1'b0);
      check(n_down, 1);
      $display("test disable done");
      r = xs();
      codes = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFD, 8'hFE, 8'hFF, {4'h0, r[3:0] | 4'h1}};
      for (int i = 0; i < 8; i++) begin
         do_idle(i[0] ? abwit_pkg::OP_IDLE_A : abwit_pkg::OP_IDLE_B, codes[i], i[1]);
         wait_sb(secs(codes[i]) * TK - 3);
      end
      $display("test table done");
      // unknown opcode mid-countdown: abort flag set, then a full period again
      do_idle(abwit_pkg::OP_IDLE_A, 8'h02, 1'b1);
      host.cmd(8'h00);
      host.rel();
      rd(abwit_pkg::REG_FAULT);
      check(q, 16'h0004);
      wait_sb(secs(8'h02) * TK - 1);
      $display("test abort done");
      finish_test();
   end
endmodule
